// ===== src/rco_top.sv
// Purpose: reference clock output block with AXI4-Lite registers
// Assumes: clk_sys at 50 MHz; source clocks slower than half of it
// Notes:   output resolution is one clk_sys cycle of jitter
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module rco_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // selectable clock inputs, asynchronous
  input  wire logic        system_osc,
  input  wire logic        high_freq_internal_osc,
  input  wire logic        low_freq_internal_osc,
  input  wire logic        mid_freq_internal_osc,
  input  wire logic        secondary_osc,
  input  wire logic        numeric_controlled_osc,
  input  wire logic        logic_cell_1_output,
  input  wire logic        logic_cell_2_output,
  input  wire logic        logic_cell_3_output,
  input  wire logic        logic_cell_4_output,
  // generated clock
  output logic             refclk_out_pin,
  output logic             refclk_internal
);
  import rco_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0]  ctrl;          // refclk_control
  logic [3:0]  src_sel;       // refclk_source_select low nibble
  logic        aw_got;        // write address captured
  logic        w_got;         // write data captured
  logic [7:0]  aw_addr;       // captured write address
  logic [31:0] w_data;        // captured write data
  logic [3:0]  w_strb;        // captured byte enables
  logic        seen_write;    // strobed write applied to ctrl or src_sel since reset

  logic [7:0]  next_ctrl;
  logic [3:0]  next_src_sel;
  logic        next_aw_got;
  logic        next_w_got;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_seen;
  logic        do_write;      // both halves of a write present

  // generator wiring
  rco_cfg_t               cfg;     // live configuration
  logic [RCO_NUM_SRC-1:0] src_raw; // asynchronous inputs
  logic [RCO_NUM_SRC-1:0] src_syn; // synchronised inputs
  logic                   src_lvl; // selected synchronised input
  logic                   running; // generator has started

  // ----------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------
  // reserved codes select a constant low; no clock ever arrives
  function automatic logic pick_src(input logic [3:0] code,
                                    input logic [RCO_NUM_SRC-1:0] v);
    if (code > RCO_SRC_LAST) begin
      return 1'b0; // RL10
    end
    return v[code]; // RL9
  endfunction : pick_src

  // read mux for a word-aligned byte address
  function automatic logic [31:0] read_word(input logic [7:0] a);
    if (a == RCO_OFS_CTRL) begin
      return {24'h000000, ctrl}; // RL12
    end else if (a == RCO_OFS_SRC) begin
      return {28'h0000000, src_sel}; // RL12
    end else if (a == RCO_OFS_STATUS) begin
      return {30'h0000000, refclk_out_pin, running};
    end
    return 32'h00000000;
  endfunction : read_word

  // mapped offsets answer okay, the rest slave error
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    if (a == RCO_OFS_CTRL || a == RCO_OFS_SRC || a == RCO_OFS_STATUS) begin
      return RCO_RESP_OKAY;
    end
    return RCO_RESP_SLVERR;
  endfunction : resp_of

  assign src_raw = {logic_cell_4_output, logic_cell_3_output,
                    logic_cell_2_output, logic_cell_1_output,
                    numeric_controlled_osc, secondary_osc,
                    mid_freq_internal_osc, low_freq_internal_osc,
                    high_freq_internal_osc, system_osc};

  rco_sync u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in (src_raw),
    .sync_out (src_syn)
  );

  assign src_lvl  = pick_src(src_sel, src_syn); // RL9
  assign cfg.en   = ctrl[RCO_EN_BIT]; // RL13
  assign cfg.duty = ctrl[RCO_DUTY_LSB +: 2]; // RL13
  assign cfg.div  = ctrl[RCO_DIV_LSB +: 3]; // RL13

  rco_gen u_gen (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .cfg     (cfg),
    .src_lvl (src_lvl),
    .out_pin (refclk_out_pin),
    .out_int (refclk_internal),
    .running (running)
  );

  // ----------------------------------------------------------------------
  // bus slave next state
  // ----------------------------------------------------------------------
  // address and data are taken in either order, then one response
  always_comb begin
    next_ctrl    = ctrl;
    next_src_sel = src_sel;
    next_aw_got  = aw_got;
    next_w_got   = w_got;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_seen    = seen_write;
    // capture each half of a write
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got  = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    // retire a taken response
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    do_write = aw_got && w_got && !s_axi_bvalid;
    if (do_write) begin
      // writes land even while running; glitches are software's risk
      if (w_strb[0] && aw_addr == RCO_OFS_CTRL) begin
        next_ctrl = w_data[7:0] & RCO_CTRL_MASK; // RL7 RL12
        next_seen = 1'b1;
      end else if (w_strb[0] && aw_addr == RCO_OFS_SRC) begin
        next_src_sel = w_data[3:0]; // RL12
        next_seen    = 1'b1;
      end
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = resp_of(aw_addr);
    end
    // reads answer one cycle after the address is taken
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = read_word(s_axi_araddr);
      next_rresp  = resp_of(s_axi_araddr);
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // register bus and configuration state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl          <= RCO_CTRL_RESET; // RL6 RL13
      src_sel       <= RCO_SRC_RESET;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      seen_write    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RCO_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RCO_RESP_OKAY;
    end else begin
      ctrl          <= next_ctrl;
      src_sel       <= next_src_sel;
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      seen_write    <= next_seen;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_ctrl_write;
    do_write && w_strb[0] && aw_addr == RCO_OFS_CTRL;
  endsequence

  sequence s_ctrl_holds;
    ctrl == $past(w_data[7:0] & RCO_CTRL_MASK);
  endsequence

  chk_reset_ctrl: assert property ( // RL6
    @(posedge clk_sys) disable iff (!rstn)
    !seen_write |-> ctrl == RCO_CTRL_RESET && src_sel == RCO_SRC_RESET)
    else $error("control left reset value without a write");

  chk_ctrl_apply: assert property ( // RL7
    @(posedge clk_sys) disable iff (!rstn)
    s_ctrl_write |=> s_ctrl_holds)
    else $error("control write not applied");

  chk_unimpl_zero: assert property ( // RL12
    @(posedge clk_sys) disable iff (!rstn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000
      && ctrl[6:5] == 2'h0)
    else $error("unimplemented bits read nonzero");

  chk_src_reserved: assert property ( // RL10
    @(posedge clk_sys) disable iff (!rstn)
    src_sel > RCO_SRC_LAST |-> !src_lvl)
    else $error("reserved source code produced a clock");

  chk_write_resp: assert property ( // AXI4-Lite port, our own choice
    @(posedge clk_sys) disable iff (!rstn)
    (aw_got && w_got && !s_axi_bvalid) |=> s_axi_bvalid [*1])
    else $error("write response missing one cycle after capture");

endmodule : rco_top

// ===== src/rco_pkg.sv
// Purpose: shared constants, types and helpers of the reference clock output
// Assumes: one system clock; 8-bit registers on 32-bit bus words
// Notes:   register offsets and the status word are local choices
//
// Functional notes
// RL1: enable starts output cleanly, no runt pulse
// RL2: clearing enable stops output at once
// RL3: divide field selects input divided by two-power
// RL4: duty field gives 75, 50, 25, 0 percent
// RL5: undivided setting follows input, duty ignored
// RL6: upper duty bit resets to one
// RL7: divider and duty writes apply while running
// RL8: software changes settings only while disabled
// RL9: source field picks one of ten inputs
// RL10: software never programs reserved source codes
// RL11: sleep never stops output while source runs
// RL12: unimplemented bits read as zero
// RL13: control layout enable, duty, divider; reset zeros; code resets ctrl to 8'h10, duty msb set
// RL14: output also offered to internal peripherals
// RL15: edges counted on the selected input clock
package rco_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] RCO_OFS_CTRL   = 8'h00; // refclk_control
  localparam logic [7:0] RCO_OFS_SRC    = 8'h04; // refclk_source_select
  localparam logic [7:0] RCO_OFS_STATUS = 8'h08; // read-only block state

  // control field positions
  localparam int RCO_EN_BIT    = 7;
  localparam int RCO_DUTY_LSB  = 3;
  localparam int RCO_DIV_LSB   = 0;
  // bits 6-5 unimplemented, masked on write
  localparam logic [7:0] RCO_CTRL_MASK  = 8'h9F;
  localparam logic [7:0] RCO_CTRL_RESET = 8'h10; // duty msb set
  localparam logic [3:0] RCO_SRC_RESET  = 4'h0;

  // bus responses
  localparam logic [1:0] RCO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RCO_RESP_SLVERR = 2'h2;

  // number of selectable clock inputs
  localparam int         RCO_NUM_SRC  = 10;
  localparam logic [3:0] RCO_SRC_LAST = 4'h9;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       en;   // refclk_module_enable
    logic [1:0] duty; // refclk_duty_sel
    logic [2:0] div;  // refclk_divide_sel
  } rco_cfg_t;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // last half-period index: 2^(div+1) - 1
  function automatic logic [7:0] rco_last(input logic [2:0] div);
    logic [8:0] full;
    full = 9'h001 << ({1'b0, div} + 4'h1);
    return 8'(full - 9'h001);
  endfunction : rco_last

  // half-periods high: duty * 2^div / 2
  function automatic logic [7:0] rco_thresh(input logic [1:0] duty,
                                            input logic [2:0] div);
    logic [9:0] prod;
    prod = {8'h00, duty} << div;
    return prod[8:1];
  endfunction : rco_thresh

endpackage : rco_pkg

// ===== src/rco_sync.sv
// Purpose: two-stage synchroniser for the asynchronous clock inputs
// Assumes: inputs are free-running clocks from outside clk_sys
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module rco_sync (
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            rstn,
  // asynchronous levels in, synchronous levels out
  input  wire logic [rco_pkg::RCO_NUM_SRC-1:0] async_in,
  output logic      [rco_pkg::RCO_NUM_SRC-1:0] sync_out
);
  import rco_pkg::*;

  logic [RCO_NUM_SRC-1:0] meta;      // first stage, metastable
  logic [RCO_NUM_SRC-1:0] next_meta; // next first stage
  logic [RCO_NUM_SRC-1:0] next_sync; // next second stage

  // stages shift forward every cycle
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  // register both stages
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule : rco_sync

// ===== src/rco_gen.sv
// Purpose: divided clock generator with duty control
// Assumes: src_lvl is the synchronised selected input clock
// Notes:   counts half-periods of the input so 25% works at divide-by-2
`timescale 1ns/1ns
module rco_gen (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // configuration and selected input level
  input  wire rco_pkg::rco_cfg_t cfg,
  input  wire logic             src_lvl,
  // generated clock and state
  output logic                  out_pin,
  output logic                  out_int,
  output logic                  running
);
  import rco_pkg::*;

  logic       prev;      // input level last cycle
  logic [7:0] cnt;       // half-period index in the output period
  logic       next_prev; // next input history
  logic       next_run;  // next running flag
  logic [7:0] next_cnt;  // next half-period index
  logic       next_out;  // next output level
  logic       rise;      // input rising edge
  logic       edg;       // any input edge
  logic [7:0] last;      // last half-period of the period
  logic [7:0] thresh;    // half-periods spent high

  // next state: start on a rising edge, stop at once
  always_comb begin
    rise      = src_lvl & ~prev;
    edg       = src_lvl ^ prev;
    last      = rco_last(cfg.div);
    thresh    = rco_thresh(cfg.duty, cfg.div);
    next_prev = src_lvl;
    next_run  = running;
    next_cnt  = cnt;
    next_out  = out_pin;
    if (!cfg.en) begin
      // no wait for the period end
      next_run = 1'b0; // RL2
      next_cnt = 8'h00;
      next_out = 1'b0;
    end else if (!running) begin
      // hold low until a rising edge opens a full first period
      next_out = 1'b0; // RL1
      if (rise) begin
        next_run = 1'b1;
        next_cnt = 8'h00;
        next_out = (cfg.div == 3'h0) ? 1'b1 : (thresh != 8'h00); // RL1
      end
    end else if (cfg.div == 3'h0) begin
      // undivided: copy the input, duty ignored
      next_out = src_lvl; // RL5
    end else begin
      // live config is used; a shrunk divider wraps early
      if (edg) begin
        next_cnt = (cnt >= last) ? 8'h00 : cnt + 8'h01; // RL3 RL7 RL15
      end
      // duty applies at once, so a zero duty drops the output now
      next_out = next_cnt < thresh; // RL4
    end
  end

  // register generator state; nothing here watches sleep
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev    <= 1'b0;
      running <= 1'b0;
      cnt     <= 8'h00;
      out_pin <= 1'b0;
      out_int <= 1'b0;
    end else begin
      prev    <= next_prev;
      running <= next_run; // RL11
      cnt     <= next_cnt;
      out_pin <= next_out;
      out_int <= next_out; // RL14
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_stop_now: assert property ( // RL2
    @(posedge clk_sys) disable iff (!rstn)
    !cfg.en |=> !out_pin && !out_int)
    else $error("output still high after disable");

  chk_start_low: assert property ( // RL1
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.en && !running && !rise) |=> !out_pin && !running)
    else $error("output started without a rising edge");

  chk_duty_zero: assert property ( // RL4
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.div != 3'h0 && cfg.duty == 2'h0) |=> !out_pin)
    else $error("zero duty drove output high");

  chk_undiv_follow: assert property ( // RL5
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.en && running && cfg.div == 3'h0) |=> out_pin == $past(src_lvl))
    else $error("undivided output not following input");

  chk_period_wrap: assert property ( // RL3
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.en && running && cfg.div != 3'h0 && edg && cnt == last)
      |=> cnt == 8'h00)
    else $error("period did not wrap at its last half");

  chk_half_step: assert property ( // RL15
    @(posedge clk_sys) disable iff (!rstn)
    (cfg.en && running && cfg.div != 3'h0 && !edg) |=> $stable(cnt))
    else $error("count moved without an input edge");

endmodule : rco_gen

// ===== tb/rco_osc_model.sv
// Purpose: free-running clock sources on the far side of the block
// Assumes: every half period stays above four clk_sys cycles
// Notes:   odd 3 ns offset keeps phases unrelated to clk_sys
`timescale 1ns/1ns
module rco_osc_model (
  // source clocks, one per source code 0..9
  output logic [rco_pkg::RCO_NUM_SRC-1:0] osc
);
  import rco_pkg::*;
  // ------------------------------------------------------------------
  // oscillators
  // ------------------------------------------------------------------
  // half period 83 ns plus 20 ns per code; they never stop, so
  // the block is never starved while enabled on a source code 0..9
  for (genvar i = 0; i < RCO_NUM_SRC; i++) begin : g_osc
    initial begin
      osc[i] = 1'b0;
      forever #(83 + 20 * i) osc[i] = ~osc[i];
    end
  end
endmodule : rco_osc_model

// ===== tb/reference_clock_output_test.sv
// Purpose: self-checking bench for the reference clock output
// Assumes: sources from rco_osc_model, AXI4-Lite master tasks below
// Notes:   output timing judged at clk_sys resolution with margins
`timescale 1ns/1ns
module reference_clock_output_test;
  import rco_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        clk_sys, rstn;                  // clock, reset
  logic [7:0]  s_axi_awaddr, s_axi_araddr;     // addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;       // data words
  logic [3:0]  s_axi_wstrb;                    // byte strobes
  logic [1:0]  s_axi_bresp, s_axi_rresp;       // responses
  logic        s_axi_awvalid, s_axi_awready;   // write address
  logic        s_axi_wvalid, s_axi_wready;     // write data
  logic        s_axi_bvalid, s_axi_bready;     // write response
  logic        s_axi_arvalid, s_axi_arready;   // read address
  logic        s_axi_rvalid, s_axi_rready;     // read data
  logic [9:0]  osc;                            // source clocks
  logic        refclk_out_pin, refclk_internal; // generated clock
  int          fail_count = 0;                 // mismatches
  int          checked = 0;                    // comparisons

  rco_osc_model u_osc (.osc(osc));
  rco_top DUT (
    .clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready,
    .system_osc(osc[0]), .high_freq_internal_osc(osc[1]),
    .low_freq_internal_osc(osc[2]), .mid_freq_internal_osc(osc[3]),
    .secondary_osc(osc[4]), .numeric_controlled_osc(osc[5]),
    .logic_cell_1_output(osc[6]), .logic_cell_2_output(osc[7]),
    .logic_cell_3_output(osc[8]), .logic_cell_4_output(osc[9]),
    .refclk_out_pin, .refclk_internal
  );

  // ------------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // high quarters of the period; undivided output ignores duty
  function automatic int exp_q(input logic [2:0] dv,
                               input logic [1:0] dy);
    return (dv == 3'h0) ? 2 : int'(dy);
  endfunction : exp_q

  // ------------------------------------------------------------------
  // bus master: ready and valid read at negedge, acted on at posedge
  // ------------------------------------------------------------------
  // readies are flops, so the negedge level is what the edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    bit ad = 0, wd = 0, bd = 0, ta, tw, tb;
    int n = 0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!bd && n < 100) begin
      @(negedge clk_sys);
      n++;
      ta = !ad && s_axi_awready === 1'b1;
      tw = !wd && s_axi_wready === 1'b1;
      tb = ad && wd && s_axi_bvalid === 1'b1;
      r  = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      ad = ad | ta;
      wd = wd | tw;
      bd = tb;
    end
    if (!bd) chk("write_answer", 0, 1);
  endtask : wr

  // read one word and compare data and response
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    bit ad = 0, bd = 0, ta, tb;
    int n = 0;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!bd && n < 100) begin
      @(negedge clk_sys);
      n++;
      ta = !ad && s_axi_arready === 1'b1;
      tb = ad && s_axi_rvalid === 1'b1;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) s_axi_rready <= 1'b0;
      ad = ad | ta;
      bd = tb;
    end
    chk("read_data", d, e);
    chk("read_resp", r, er);
  endtask : rc

  // ------------------------------------------------------------------
  // output measurement over eight whole periods
  // ------------------------------------------------------------------
  // live changes may glitch, so two periods are skipped first
  task automatic meas(input int s, input logic [2:0] dv,
                      input logic [1:0] dy, input bit live);
    int hp = 83 + 20 * s, q = exp_q(dv, dy), st = live ? 3 : 1;
    int h = (dv == 3'h0) ? 1 : ((int'(dy) << dv) >> 1);
    int n = 0, k = 0, tot = 0, hi = 0, run = 0, mn = 1 << 20, bad = 0;
    int d;
    bit none = (q == 0 || s > 9);
    logic prev = refclk_out_pin;
    while (n < st + 8 && k < (none ? 600 : 20000)) begin
      @(negedge clk_sys);
      k++;
      if (refclk_internal !== refclk_out_pin) bad++;
      if (refclk_out_pin === 1'b1 && prev === 1'b0) n++;
      if (refclk_out_pin === 1'b0 && prev === 1'b1 && n >= st) begin
        mn = (run < mn) ? run : mn;
      end
      if (n >= st && n < st + 8) begin
        tot++;
        hi += int'(refclk_out_pin === 1'b1);
      end
      run = (refclk_out_pin === 1'b1) ? run + 1 : 0;
      prev = refclk_out_pin;
    end
    chk("internal_copy", bad, 0);
    if (none) begin
      chk("no_edges", n, 0);
    end else begin
      d = tot * 20 - (16 << dv) * hp;
      chk("period_ns", d <= 80 && d >= -80, 1);
      d = hi * 4 - q * tot;
      chk("duty", d <= 72 && d >= -72, 1);
      if (!live) chk("no_runt", mn * 20 + 60 >= h * hp, 1);
    end
  endtask : meas

  // one configuration, fresh from disabled or changed while running
  task automatic run_cfg(input int s, input logic [2:0] dv,
                         input logic [1:0] dy, input bit live);
    logic [1:0] r;
    int k = 0;
    if (!live) begin
      wr(RCO_OFS_CTRL, 32'h10, 4'hF, r);
      wr(RCO_OFS_SRC, 32'(s), 4'hF, r);
    end
    wr(RCO_OFS_CTRL, {24'h0, 3'h4, dy, dv}, 4'hF, r);
    meas(s, dv, dy, live);
    if (live && exp_q(dv, dy) > 0) begin
      while (refclk_out_pin !== 1'b1 && k < 20000) begin
        @(negedge clk_sys);
        k++;
      end
      wr(RCO_OFS_CTRL, {24'h0, 3'h0, dy, dv}, 4'hF, r);
      @(negedge clk_sys);
      chk("stop_now", refclk_out_pin, 1'b0);
    end
  endtask : run_cfg

  // ------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // longest expected run is well below this span
  initial begin
    #1_900_000;
    fail_count++;
    finish_test();
  end

  initial begin
    logic [1:0] r;
    rstn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    void'($urandom(55));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rc(RCO_OFS_CTRL, 32'h10, RCO_RESP_OKAY);
    rc(RCO_OFS_SRC, 32'h0, RCO_RESP_OKAY);
    wr(RCO_OFS_CTRL, 32'hFFFFFF7F, 4'hF, r);
    rc(RCO_OFS_CTRL, 32'h1F, RCO_RESP_OKAY);
    wr(RCO_OFS_CTRL, 32'h8F, 4'h0, r);
    chk("strobe_resp", r, RCO_RESP_OKAY);
    rc(RCO_OFS_CTRL, 32'h1F, RCO_RESP_OKAY);
    wr(RCO_OFS_SRC, 32'hFF, 4'hF, r);
    rc(RCO_OFS_SRC, 32'hF, RCO_RESP_OKAY);
    wr(8'h0C, 32'h1, 4'hF, r);
    chk("unmapped_wr", r, RCO_RESP_SLVERR);
    rc(8'h0C, 32'h0, RCO_RESP_SLVERR);
    // every source fresh, then a live change of divider and duty
    for (int i = 0; i < 20; i++) begin
      run_cfg(i / 2, 3'($urandom % 5), 2'($urandom), i[0]);
    end
    run_cfg(0, 3'h7, 2'h3, 1'b0);
    run_cfg(9, 3'h1, 2'h1, 1'b0);
    run_cfg(3, 3'h0, 2'h0, 1'b0);
    run_cfg(12, 3'h2, 2'h2, 1'b0);
    rc(RCO_OFS_STATUS, 32'h0, RCO_RESP_OKAY);
    finish_test();
  end
endmodule : reference_clock_output_test
